// ==== logic/sfc_cmd_core.sv ====
// Status write, address mode and read command core of a serial flash.
// Assumes the array answers array_data_in combinationally from array_addr_out.
// How it works
// - Status writes touch only the writable protect, lock, quad, drive, config bits.
// - One-time lock bits, once stored as one, never return to zero.
// - Non-volatile status write needs the write enable latch set beforehand.
// - After volatile enable, a status write updates only live copies, latch stays zero.
// - Volatile writes cannot clear the status lock bit or one-time lock bits.
// - Pin and software resets discard live values and reload them from stored values.
// - Chip select rise starts a timed non-volatile write; busy is one meanwhile.
// - The write enable latch clears when the timed write finishes.
// - Volatile values land within the refresh time; busy stays zero.
// - Status writes work in both modes; quad enable frozen in four-line mode.
// - Every status bit resets to zero at power-up.
// - Legacy write: sixteen bits write registers one and two, eight bits only one.
// - Enter command selects 32-bit addressing.
// - Exit command returns to 24-bit addressing.
// - Code and address sampled on rising edges, data out on falling, MSB first; double-rate reads use both edges for address and data.
// - Read address increments per byte and streams until chip select rises.
// - Reads issued while busy are ignored and leave the cycle alone.
// - Plain reads are refused in four-line command mode.
// - The explicit four-byte plain read always takes 32 address bits.
// - Single-line fast read inserts eight dummy clocks.
// - Four-line fast read dummy count comes from the parameter field, default 2.
// - Double-rate fast read takes address on both edges and six dummy clocks.
// - Write enable sets the latch.
// - Status reads are accepted at any time, even when busy.
`timescale 1ns/1ps
module sfc_cmd_core
  import sfc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic hw_reset_n_in,
  input wire logic four_line_command_mode_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] sio_in,
  output logic [3:0] sio_out,
  output logic [3:0] sio_oe_out,
  output logic [31:0] array_addr_out,
  input wire logic [7:0] array_data_in,
  output logic [23:0] status_out,
  output logic addr32_mode_out
);
  typedef struct packed {
    logic cs1;
    logic cs2;
    logic cs3;
    logic hr1;
    logic hr2;
    logic seen;
    sfc_mstate_t st;
    logic [9:0] tmr;
    logic [23:0] live;
    logic [23:0] nv;
    logic [23:0] pend;
    logic write_enable_latch;
    logic vwen;
    logic a32;
    logic rsten;
    logic [2:0] dsel;
    sfc_cfg_t cfg;
  } sfc_mc_t;

  typedef struct packed {
    sfc_lphase_t ph;
    logic [5:0] cnt;
    logic [31:0] sr;
    logic [5:0] alen;
    logic [4:0] dmy;
    logic [2:0] idx;
    logic [31:0] ptr;
    logic [7:0] txb;
    logic fb;
    logic quad;
    logic dtr;
    logic stat_rd;
    logic [1:0] ssel;
    logic tail;
    logic [3:0] oe;
    logic [3:0] p;
  } sfc_lk_t;

  typedef struct packed {
    sfc_frame_t fr;
    sfc_cfg_t sy1;
    sfc_cfg_t sy2;
  } sfc_cap_t;

  typedef struct packed {
    logic [3:0] n;
    logic fall;
  } sfc_ng_t;

  sfc_mc_t m;
  sfc_mc_t nxt_m;
  sfc_lk_t lk;
  sfc_lk_t nxt_lk;
  sfc_cap_t cp;
  sfc_cap_t nxt_cp;
  sfc_ng_t ng;
  sfc_ng_t nxt_ng;

  logic frm_end;
  logic soft_rst;
  logic [23:0] wmask;
  logic [23:0] bmask;
  logic [23:0] dword;
  logic [23:0] otp;
  logic [23:0] base;
  logic [23:0] merged;
  logic [2:0] be;
  sfc_frame_t f;
  sfc_cfg_t cfg;
  logic [5:0] w;
  logic [5:0] ncnt;
  logic [5:0] dn;
  logic [31:0] sh;
  logic [31:0] dsh;
  logic [5:0] dcnt;
  logic [31:0] adr;
  logic busy_l;
  logic [7:0] sbyte;
  logic [7:0] src;

  // Core domain: chip select edge, status store, timed write cycles.
  always_comb
  begin
    nxt_m = m;
    f = cp.fr;
    nxt_m.cs1 = cs_n_in;
    nxt_m.cs2 = m.cs1;
    nxt_m.cs3 = m.cs2;
    nxt_m.hr1 = hw_reset_n_in;
    nxt_m.hr2 = m.hr1;
    // The frame fields stay still here because the serial clock stops with chip select high.
    frm_end = m.cs2 & ~m.cs3 & (f.seq != m.seen);
    soft_rst = 1'b0;
    wmask = four_line_command_mode_in ? (WR_MASK & ~QUAD_EN_MASK) : WR_MASK;
    be = 3'h0;
    dword = 24'h000000;
    case (f.op)
      OP_WSR1:
      begin
        be = {1'b0, f.nb == 2'h2, f.nb != 2'h0};
        dword = {8'h00, f.d1, f.d0};
      end
      OP_WSR2:
      begin
        be = {1'b0, f.nb != 2'h0, 1'b0};
        dword = {8'h00, f.d0, 8'h00};
      end
      OP_WSR3:
      begin
        be = {f.nb != 2'h0, 2'h0};
        dword = {f.d0, 16'h0000};
      end
      default:
        be = 3'h0;
    endcase
    bmask = {{8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    otp = m.write_enable_latch ? OTP_NV_MASK : OTP_VOL_MASK;
    base = m.write_enable_latch ? m.nv : m.live;
    merged = (base & ~bmask) | (dword & bmask) | (base & otp) | (m.nv & OTP_NV_MASK);
    case (m.st)
      MS_NV:
      begin
        nxt_m.tmr = m.tmr - TMR_ONE;
        if (m.tmr == 10'h000)
        begin
          nxt_m.nv = m.pend;
          nxt_m.live = m.pend;
          nxt_m.write_enable_latch = 1'b0;
          nxt_m.st = MS_IDLE;
        end
      end
      MS_VOL:
      begin
        nxt_m.tmr = m.tmr - TMR_ONE;
        if (m.tmr == 10'h000)
        begin
          nxt_m.live = m.pend;
          nxt_m.st = MS_IDLE;
        end
      end
      default:
        nxt_m.st = MS_IDLE;
    endcase
    if (m.cs2 & ~m.cs3)
    begin
      nxt_m.seen = f.seq;
    end
    // Commands other than status reads are dropped while a timed write runs.
    if (frm_end && m.st == MS_IDLE)
    begin
      nxt_m.vwen = 1'b0;
      nxt_m.rsten = 1'b0;
      case (f.op)
        OP_WR_EN:
          nxt_m.write_enable_latch = 1'b1;
        OP_WR_DIS:
          nxt_m.write_enable_latch = 1'b0;
        OP_VOL_EN:
          nxt_m.vwen = 1'b1;
        OP_ADDR32_ON:
          nxt_m.a32 = 1'b1;
        OP_ADDR32_OFF:
          nxt_m.a32 = 1'b0;
        OP_SET_PARAM:
          if (four_line_command_mode_in && f.nb != 2'h0)
          begin
            nxt_m.dsel = f.d0[6:4];
          end
        OP_RST_EN:
          nxt_m.rsten = 1'b1;
        OP_RST:
          soft_rst = m.rsten;
        OP_WSR1, OP_WSR2, OP_WSR3:
          if (be != 3'h0 && m.write_enable_latch)
          begin
            nxt_m.pend = merged;
            nxt_m.st = MS_NV;
            nxt_m.tmr = NV_TMR_LOAD;
          end
          else if (be != 3'h0 && m.vwen)
          begin
            nxt_m.pend = merged;
            nxt_m.st = MS_VOL;
            nxt_m.tmr = VOL_TMR_LOAD;
          end
        default:
          nxt_m.rsten = 1'b0;
      endcase
    end
    if (soft_rst || !m.hr2)
    begin
      nxt_m.live = m.nv;
      nxt_m.write_enable_latch = 1'b0;
      nxt_m.vwen = 1'b0;
      nxt_m.rsten = 1'b0;
      nxt_m.a32 = m.nv[POS_ADDR_DEF];
      nxt_m.dsel = DSEL_DEF;
      nxt_m.st = MS_IDLE;
    end
    nxt_m.cfg.stat = {nxt_m.live[23:2], nxt_m.write_enable_latch, nxt_m.st == MS_NV};
    nxt_m.cfg.addr32 = nxt_m.a32;
    nxt_m.cfg.dsel = nxt_m.dsel;
    nxt_m.cfg.four_line = four_line_command_mode_in;
    if (!rst_n_in)
    begin
      nxt_m = '0;
      nxt_m.cs1 = 1'b1;
      nxt_m.cs2 = 1'b1;
      nxt_m.cs3 = 1'b1;
      nxt_m.hr1 = 1'b1;
      nxt_m.hr2 = 1'b1;
      nxt_m.st = MS_IDLE;
      nxt_m.dsel = DSEL_DEF;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    m <= nxt_m;
  end

  assign status_out = m.cfg.stat;
  assign addr32_mode_out = m.cfg.addr32;

  // Link domain, rising edges: command, address, dummy and data phases.
  always_comb
  begin
    nxt_lk = lk;
    nxt_cp = cp;
    nxt_cp.sy1 = m.cfg;
    nxt_cp.sy2 = cp.sy1;
    cfg = cp.sy2;
    busy_l = cfg.stat[POS_BUSY];
    w = cfg.four_line ? 6'h04 : 6'h01;
    sh = cfg.four_line ? {lk.sr[27:0], sio_in} : {lk.sr[30:0], sio_in[0]};
    ncnt = lk.cnt + w;
    dn = lk.cnt + 6'h01;
    dsh = (lk.cnt == 6'h00) ? {lk.sr[30:0], sio_in[0]} : {lk.sr[29:0], ng.fall, sio_in[0]};
    dcnt = (lk.cnt == 6'h00) ? 6'h01 : lk.cnt + 6'h02;
    adr = (lk.alen == ADDR32) ? sh : {8'h00, sh[23:0]};
    case (lk.ph)
      LP_CMD:
      begin
        nxt_lk.sr = sh;
        nxt_lk.cnt = ncnt;
        nxt_lk.quad = cfg.four_line;
        if (ncnt == CMD_BITS)
        begin
          nxt_cp.fr.seq = ~cp.fr.seq;
          nxt_cp.fr.op = sh[7:0];
          nxt_cp.fr.nb = 2'h0;
          nxt_lk.cnt = 6'h00;
          nxt_lk.ph = LP_SKIP;
          nxt_lk.alen = cfg.addr32 ? ADDR32 : ADDR24;
          case (sh[7:0])
            OP_READ, OP_READ32:
              if (!cfg.four_line && !busy_l)
              begin
                nxt_lk.ph = LP_ADDR;
                nxt_lk.dmy = 5'h00;
                if (sh[7:0] == OP_READ32)
                begin
                  nxt_lk.alen = ADDR32;
                end
              end
            OP_FAST:
              if (!busy_l)
              begin
                nxt_lk.ph = LP_ADDR;
                nxt_lk.dmy = cfg.four_line ? {1'b0, cfg.dsel, 1'b0} + DUMMY_BASE : DUMMY_FAST;
              end
            OP_FAST_DTR:
              if (!cfg.four_line && !busy_l)
              begin
                nxt_lk.ph = LP_ADDR;
                nxt_lk.dtr = 1'b1;
                nxt_lk.dmy = DUMMY_DTR;
              end
            OP_RSR1, OP_RSR2, OP_RSR3:
            begin
              nxt_lk.ph = LP_OUT;
              nxt_lk.stat_rd = 1'b1;
              nxt_lk.idx = 3'h7;
              nxt_lk.oe = cfg.four_line ? OE_QUAD : OE_SINGLE;
              nxt_lk.ssel = (sh[7:0] == OP_RSR1) ? 2'h0 : (sh[7:0] == OP_RSR2) ? 2'h1 : 2'h2;
            end
            OP_WSR1, OP_WSR2, OP_WSR3, OP_SET_PARAM:
              nxt_lk.ph = LP_IN;
            default:
              nxt_lk.ph = LP_SKIP;
          endcase
        end
      end
      LP_ADDR:
        if (lk.dtr)
        begin
          nxt_lk.sr = dsh;
          nxt_lk.cnt = dcnt;
          if (dcnt == lk.alen - 6'h01)
          begin
            nxt_lk.ph = LP_DUMMY;
            nxt_lk.cnt = 6'h00;
            nxt_lk.tail = 1'b1;
          end
        end
        else
        begin
          nxt_lk.sr = sh;
          nxt_lk.cnt = ncnt;
          if (ncnt == lk.alen)
          begin
            nxt_lk.ptr = adr;
            nxt_lk.cnt = 6'h00;
            nxt_lk.idx = 3'h7;
            if (lk.dmy == 5'h00)
            begin
              nxt_lk.ph = LP_OUT;
              nxt_lk.oe = lk.quad ? OE_QUAD : OE_SINGLE;
            end
            else
            begin
              nxt_lk.ph = LP_DUMMY;
            end
          end
        end
      LP_DUMMY:
      begin
        // The data line is not driven here; output enable stays zero.
        nxt_lk.cnt = dn;
        if (lk.tail)
        begin
          nxt_lk.tail = 1'b0;
          nxt_lk.ptr = (lk.alen == ADDR32) ? {lk.sr[30:0], ng.fall} : {8'h00, lk.sr[22:0], ng.fall};
        end
        if (dn[4:0] == lk.dmy)
        begin
          nxt_lk.ph = LP_OUT;
          nxt_lk.idx = 3'h7;
          nxt_lk.oe = lk.quad ? OE_QUAD : OE_SINGLE;
          if (lk.dtr)
          begin
            nxt_lk.txb = array_data_in;
            nxt_lk.ptr = lk.ptr + 32'h00000001;
          end
        end
      end
      LP_OUT:
        if (lk.dtr)
        begin
          // Rising bit goes out now, its falling partner is parked in fb first.
          nxt_lk.p = {2'b00, lk.txb[lk.idx] ^ ng.n[1], 1'b0};
          nxt_lk.fb = lk.txb[lk.idx - 3'h1];
          nxt_lk.idx = lk.idx - 3'h2;
          if (lk.idx == 3'h1)
          begin
            nxt_lk.txb = array_data_in;
            nxt_lk.ptr = lk.ptr + 32'h00000001;
            nxt_lk.idx = 3'h7;
          end
        end
        else if (lk.quad)
        begin
          nxt_lk.idx = (lk.idx == 3'h7) ? 3'h3 : 3'h7;
          if (lk.idx == 3'h3 && !lk.stat_rd)
          begin
            nxt_lk.ptr = lk.ptr + 32'h00000001;
          end
        end
        else
        begin
          nxt_lk.idx = lk.idx - 3'h1;
          if (lk.idx == 3'h0 && !lk.stat_rd)
          begin
            nxt_lk.ptr = lk.ptr + 32'h00000001;
          end
        end
      LP_IN:
      begin
        nxt_lk.sr = sh;
        nxt_lk.cnt = ncnt;
        if (ncnt == BYTE1_BITS)
        begin
          nxt_cp.fr.d0 = sh[7:0];
          nxt_cp.fr.nb = 2'h1;
        end
        if (ncnt == BYTE2_BITS)
        begin
          nxt_cp.fr.d1 = sh[7:0];
          nxt_cp.fr.nb = 2'h2;
          nxt_lk.ph = LP_SKIP;
        end
      end
      default:
        nxt_lk.ph = LP_SKIP;
    endcase
  end

  // Chip select high ends every frame, since no clock edge follows it.
  always_ff @(posedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      lk <= '{ph: LP_CMD, default: '0};
    end
    else
    begin
      lk <= nxt_lk;
    end
  end

  // Frame record and config copy outlive chip select; only power-up clears them.
  // The config copy moves only on serial clock edges, so a mode change needs one idle frame.
  always_ff @(posedge sclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cp <= '0;
    end
    else
    begin
      cp <= nxt_cp;
    end
  end

  assign array_addr_out = lk.ptr;
  assign sio_oe_out = lk.oe;

  // Link domain, falling edges: single-rate output and double-rate input capture.
  always_comb
  begin
    nxt_ng = ng;
    nxt_ng.fall = sio_in[0];
    sbyte = (lk.ssel == 2'h2) ? cp.sy2.stat[23:16] :
            (lk.ssel == 2'h1) ? cp.sy2.stat[15:8] : cp.sy2.stat[7:0];
    src = lk.stat_rd ? sbyte : array_data_in;
    if (lk.ph == LP_OUT)
    begin
      if (lk.dtr)
      begin
        nxt_ng.n = {2'b00, lk.fb, 1'b0} ^ lk.p;
      end
      else if (lk.quad)
      begin
        nxt_ng.n = (lk.idx[2] ? src[7:4] : src[3:0]) ^ lk.p;
      end
      else
      begin
        nxt_ng.n = {2'b00, src[lk.idx], 1'b0} ^ lk.p;
      end
    end
  end

  always_ff @(negedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      ng <= '0;
    end
    else
    begin
      ng <= nxt_ng;
    end
  end

  // Two edge halves recombine so the line can change on both clock edges.
  assign sio_out = lk.p ^ ng.n;
endmodule : sfc_cmd_core

// ==== shared/sfc_pkg.sv ====
// Constants and carrier types for the serial flash command core.
// Assumes a 25 MHz core clock; the serial clock belongs to the host.
package sfc_pkg;
  localparam int CLK_NS = 40;
  localparam int NV_WRITE_TIME_NS = 15000;
  localparam int NV_WRITE_CYC = (NV_WRITE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int VOL_REFRESH_TIME_NS = 50;
  localparam int VOL_RAW = VOL_REFRESH_TIME_NS / CLK_NS;
  localparam int VOL_REFRESH_CYC = (VOL_RAW < 1) ? 1 : VOL_RAW;
  localparam logic [9:0] NV_TMR_LOAD = 10'(NV_WRITE_CYC - 1);
  localparam logic [9:0] VOL_TMR_LOAD = 10'(VOL_REFRESH_CYC - 1);
  localparam logic [9:0] TMR_ONE = 10'h001;

  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_VOL_EN = 8'h50;
  localparam logic [7:0] OP_WSR1 = 8'h01;
  localparam logic [7:0] OP_WSR2 = 8'h31;
  localparam logic [7:0] OP_WSR3 = 8'h11;
  localparam logic [7:0] OP_ADDR32_ON = 8'hB7;
  localparam logic [7:0] OP_ADDR32_OFF = 8'hE9;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ32 = 8'h13;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_FAST_DTR = 8'h0D;
  localparam logic [7:0] OP_RSR1 = 8'h05;
  localparam logic [7:0] OP_RSR2 = 8'h35;
  localparam logic [7:0] OP_RSR3 = 8'h15;
  localparam logic [7:0] OP_SET_PARAM = 8'hC0;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;

  // Status word is {reg3, reg2, reg1}.
  localparam logic [23:0] WR_MASK = 24'hE67BFC;
  localparam logic [23:0] QUAD_EN_MASK = 24'h000200;
  localparam logic [23:0] OTP_NV_MASK = 24'h003800;
  localparam logic [23:0] OTP_VOL_MASK = 24'h003900;
  localparam int POS_BUSY = 0;
  localparam int POS_ADDR_DEF = 17;

  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR24 = 6'h18;
  localparam logic [5:0] ADDR32 = 6'h20;
  localparam logic [5:0] BYTE1_BITS = 6'h08;
  localparam logic [5:0] BYTE2_BITS = 6'h10;
  localparam logic [4:0] DUMMY_FAST = 5'h08;
  localparam logic [4:0] DUMMY_DTR = 5'h06;
  localparam logic [4:0] DUMMY_BASE = 5'h02;
  localparam logic [2:0] DSEL_DEF = 3'h0;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_QUAD = 4'hF;

  typedef enum logic [2:0] {MS_IDLE = 3'h1, MS_NV = 3'h2, MS_VOL = 3'h4} sfc_mstate_t;
  typedef enum logic [5:0] {
    LP_CMD = 6'h01, LP_ADDR = 6'h02, LP_DUMMY = 6'h04,
    LP_OUT = 6'h08, LP_IN = 6'h10, LP_SKIP = 6'h20
  } sfc_lphase_t;
  typedef struct packed {
    logic [23:0] stat;
    logic addr32;
    logic [2:0] dsel;
    logic four_line;
  } sfc_cfg_t;
  typedef struct packed {
    logic seq;
    logic [7:0] op;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [1:0] nb;
  } sfc_frame_t;
endpackage : sfc_pkg

// ==== bench/sfc_cmd_core_properties.sv ====
// Concurrent checks on the ports of the serial flash command core.
// Assumes it is bound to sfc_cmd_core and sees nothing but its ports.
`timescale 1ns/1ps
module sfc_cmd_core_properties
  import sfc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic hw_reset_n_in,
  input wire logic four_line_command_mode_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] sio_in,
  input wire logic [3:0] sio_out,
  input wire logic [3:0] sio_oe_out,
  input wire logic [31:0] array_addr_out,
  input wire logic [7:0] array_data_in,
  input wire logic [23:0] status_out,
  input wire logic addr32_mode_out
);
  logic [9:0] busy_cnt_ff;
  logic [3:0] hw_hist_ff;
  logic hw_ok;
  // Reloads lag the pin through its synchroniser, so sticky checks wait for a quiet pin.
  assign hw_ok = hw_reset_n_in & (&hw_hist_ff);
  always_ff @(posedge mclk_in)
  begin
    hw_hist_ff <= {hw_hist_ff[2:0], hw_reset_n_in};
    busy_cnt_ff <= status_out[POS_BUSY] ? busy_cnt_ff + 10'h001 : 10'h000;
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_idle_lines_quiet: assert property (cs_n_in |-> !sio_oe_out && !array_addr_out)
    else $error("link outputs active with chip select high");
  a_oe_mode_match: assert property (sio_oe_out != 4'h0 |->
    sio_oe_out == (four_line_command_mode_in ? OE_QUAD : OE_SINGLE))
    else $error("output enable pattern does not fit the mode");
  a_busy_full_length: assert property ($fell(status_out[0]) && hw_ok |->
    busy_cnt_ff == 10'(NV_WRITE_CYC))
    else $error("busy period length wrong");
  a_busy_count_bound: assert property (busy_cnt_ff <= 10'(NV_WRITE_CYC))
    else $error("busy period too long");
  a_busy_holds_on: assert property ($rose(status_out[0]) |-> status_out[0] [*8])
    else $error("busy dropped early");
  a_latch_cleared: assert property ($fell(status_out[0]) |-> !status_out[1])
    else $error("write enable latch left set after write");
  a_busy_needs_latch: assert property (status_out[0] |-> status_out[1])
    else $error("busy without write enable latch");
  a_ro_bits_zero: assert property ((status_out & ~(WR_MASK | 24'h000003)) == 24'h0)
    else $error("read-only status bit set");
  a_otp_sticky: assert property (hw_ok |->
    ($past(status_out[13:11]) & ~status_out[13:11]) == 3'h0)
    else $error("lock bit returned to zero");
  a_quad_frozen: assert property (hw_ok && four_line_command_mode_in &&
    $past(four_line_command_mode_in) |-> $stable(status_out[9]))
    else $error("quad enable changed in four-line mode");
endmodule : sfc_cmd_core_properties

// ==== bench/sfc_host_model.sv ====
// Host controller model: drives chip select, serial clock and data lines.
// Assumes the bench resolves the shared lines and returns them on line_in.
`timescale 1ns/1ps
module sfc_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] sio_out,
  input wire logic [3:0] line_in,
  input wire logic [3:0] oe_in
);
  localparam int HALF = 16;
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sio_out = 4'h5;
  end
  // The clock stands low between frames; released lines toggle so no stale bit is read.
  task automatic frame(input logic quad, input logic [63:0] tx, input int ntx,
      input int nrx, output logic [63:0] rx, output logic oe_seen);
    int n;
    n = quad ? ntx / 4 : ntx;
    rx = 64'h0;
    oe_seen = 1'b0;
    cs_n_out = 1'b0;
    for (int i = 0; i < n + nrx; i++)
    begin
      if (i < n)
        sio_out = quad ? tx[63:60] : {~sio_out[3:1], tx[63]};
      else
        sio_out = ~sio_out;
      tx = quad ? tx << 4 : tx << 1;
      #HALF;
      if (i >= n)
        rx = {rx[62:0], line_in[1]};
      oe_seen = oe_seen | (|oe_in);
      sclk_out = 1'b1;
      #HALF;
      sclk_out = 1'b0;
    end
    #HALF;
    cs_n_out = 1'b1;
    sio_out = ~sio_out;
    #400;
  endtask : frame
endmodule : sfc_host_model

// ==== bench/sfc_cmd_core_bench.sv ====
// Self-checking bench for the serial flash command core.
// Assumes the host model and the property checker are compiled alongside.
`timescale 1ns/1ps
module sfc_cmd_core_bench;
  import sfc_pkg::*;
  logic mclk, rst_n, hw_n, quad, sclk, cs_n, a32, oe_seen;
  logic [3:0] host_sio, dev_sio, dev_oe, line;
  logic [31:0] arr_addr;
  logic [7:0] arr_data;
  logic [23:0] status;
  logic [63:0] rx;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int busy_cyc = 0;
  function automatic logic [7:0] fold(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[31:24] ^ 8'h5A;
  endfunction : fold
  assign line = (dev_oe & dev_sio) | (~dev_oe & host_sio);
  // Array bytes fold address bits 7:0, 15:8 and 31:24, so a wrong increment in those bits changes the data seen.
  assign arr_data = fold(arr_addr);
  sfc_cmd_core i_sfc_cmd_core (.mclk_in(mclk), .rst_n_in(rst_n), .hw_reset_n_in(hw_n),
    .four_line_command_mode_in(quad), .sclk_in(sclk), .cs_n_in(cs_n), .sio_in(line),
    .sio_out(dev_sio), .sio_oe_out(dev_oe), .array_addr_out(arr_addr),
    .array_data_in(arr_data), .status_out(status), .addr32_mode_out(a32));
  sfc_host_model i_sfc_host_model (.sclk_out(sclk), .cs_n_out(cs_n), .sio_out(host_sio),
    .line_in(line), .oe_in(dev_oe));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(negedge mclk)
  begin
    cyc++;
    if (status[POS_BUSY] === 1'b1)
      busy_cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done
  task automatic sync();
    @(posedge mclk);
    #2;
  endtask : sync
  task automatic op(input logic [7:0] code);
    i_sfc_host_model.frame(quad, {code, 56'h0}, 8, 0, rx, oe_seen);
  endtask : op
  task automatic wsr(input logic [7:0] code, input logic [15:0] d, input int nb);
    i_sfc_host_model.frame(quad, {code, d, 40'h0}, 8 + nb, 0, rx, oe_seen);
  endtask : wsr
  task automatic rd(input logic [7:0] code, input logic [31:0] a, input int ab, input int dum);
    logic [63:0] tx;
    tx = {code, 56'h0} | ({32'h0, a} << (56 - ab));
    i_sfc_host_model.frame(1'b0, tx, 8 + ab + dum, 16, rx, oe_seen);
    chk("read bytes", rx[31:0], {16'h0, fold(a), fold(a + 32'h1)});
  endtask : rd
  initial
  begin
    rst_n = 1'b0;
    hw_n = 1'b1;
    quad = 1'b0;
    repeat (8) @(posedge mclk);
    #2 rst_n = 1'b1;
    repeat (4) sync();
    chk("status", status, 24'h0);
    chk("addr mode", a32, 1'b0);
    done("reset");
    op(OP_WR_EN);
    chk("latch", status[1], 1'b1);
    busy_cyc = 0;
    wsr(OP_WSR1, 16'hFFFF, 16);
    chk("busy", status[0], 1'b1);
    i_sfc_host_model.frame(1'b0, {OP_RSR1, 56'h0}, 8, 8, rx, oe_seen);
    chk("status poll", rx[7:0], 8'h03);
    i_sfc_host_model.frame(1'b0, {OP_READ, 56'h0}, 32, 8, rx, oe_seen);
    chk("refused read", oe_seen, 1'b0);
    for (int i = 0; i < 600 && status[0] !== 1'b0; i++) @(posedge mclk);
    sync();
    chk("busy length", busy_cyc, NV_WRITE_CYC);
    chk("status", status, 24'h007BFC);
    done("stored write");
    op(OP_VOL_EN);
    wsr(OP_WSR2, 16'h0000, 8);
    chk("status", status, 24'h0039FC);
    op(OP_VOL_EN);
    wsr(OP_WSR1, 16'h0400, 8);
    chk("status", status, 24'h003904);
    done("live write");
    sync();
    hw_n = 1'b0;
    repeat (3) sync();
    hw_n = 1'b1;
    repeat (6) sync();
    chk("status", status, 24'h007BFC);
    done("pin reset");
    quad = 1'b1;
    repeat (2) sync();
    // The link sees a mode change only after two serial clock edges, so an idle frame goes first.
    op(8'h00);
    op(OP_VOL_EN);
    wsr(OP_WSR2, 16'h0000, 8);
    chk("status", status, 24'h003BFC);
    i_sfc_host_model.frame(1'b1, {OP_READ, 56'h0}, 32, 8, rx, oe_seen);
    chk("refused read", oe_seen, 1'b0);
    sync();
    quad = 1'b0;
    repeat (2) sync();
    op(8'h00);
    done("four line");
    op(OP_ADDR32_ON);
    chk("addr mode", a32, 1'b1);
    rd(OP_READ, 32'h010000FF, 32, 0);
    op(OP_ADDR32_OFF);
    chk("addr mode", a32, 1'b0);
    rd(OP_READ, 32'h0000FFFF, 24, 0);
    rd(OP_READ32, 32'h02FFFFFF, 32, 0);
    rd(OP_FAST, 32'h000012FF, 24, 8);
    done("reads");
    print_verdict();
  end
endmodule : sfc_cmd_core_bench
bind sfc_cmd_core sfc_cmd_core_properties i_sfc_cmd_core_properties (.mclk_in(mclk_in),
  .rst_n_in(rst_n_in), .hw_reset_n_in(hw_reset_n_in), .sclk_in(sclk_in),
  .four_line_command_mode_in(four_line_command_mode_in), .cs_n_in(cs_n_in),
  .sio_in(sio_in), .sio_out(sio_out), .sio_oe_out(sio_oe_out),
  .array_addr_out(array_addr_out), .array_data_in(array_data_in),
  .status_out(status_out), .addr32_mode_out(addr32_mode_out));
